// ### hdl/ssa_cfg.svh
// offsets, field positions, reset values and counts of the set-point converter
`ifndef SSA_CFG_SVH
`define SSA_CFG_SVH
`define SSA_CNT_W      16
`define SSA_OFS_CTRL   8'h00
`define SSA_OFS_CHARGE 8'h04
`define SSA_OFS_SPEED  8'h08
`define SSA_OFS_PULSE  8'h0C
`define SSA_OFS_STAT   8'h10
`define SSA_OFS_MASK   8'h14
`define SSA_OFS_RESULT 8'h18
`define SSA_OFS_TIMER  8'h1C
`define SSA_OFS_TAP    8'h20
`define SSA_OFS_C1CTL  8'h24
`define SSA_OFS_C1VAL  8'h28
`define SSA_CTRL_CONV  0
`define SSA_CTRL_FIRE  1
`define SSA_ST_CONV    0
`define SSA_ST_ZC      1
`define SSA_ST_FIRE    2
`define SSA_ST_SPARE   3
`define SSA_ST_W       4
`define SSA_CHARGE_RST 16'h0400
`define SSA_PULSE_RST  16'h0A14
`define SSA_TAP_SHIFT  9
`define SSA_PULSES     2'h3
`define SSA_CODE_MAX   8'hFF
`endif

// ### hdl/ssa_pkg.sv
// types shared by the set-point converter
package ssa_pkg;
    typedef enum {S_IDLE, S_CHARGE, S_WAITZC, S_DISCH, S_CALC} ssa_conv_t;
    typedef enum {F_IDLE, F_ARMED, F_HIGH, F_GAP} ssa_fire_t;
    typedef enum logic [1:0] {CC_CAPTURE, CC_SET, CC_CLEAR, CC_TOGGLE} ssa_ccmode_t;
    typedef struct packed {
        logic [2:0] drv;
        logic [2:0] oeN;
    } ssa_pot_t;
endpackage

// ### hdl/ssa_top.sv
// single-slope set-point converter, three-channel timer and gate pulse generator
`timescale 1ns/100ps
`include "ssa_cfg.svh"
module ssa_top
    import ssa_pkg::*;
#(
    parameter int CW = `SSA_CNT_W
) (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wrStb,
    input  wire logic        rdStb,
    output logic      [31:0] rdata,
    output logic             irq,
    input  wire logic        senseIn,
    input  wire logic        zcIn,
    input  wire logic        spareIn,
    output logic             spareOut,
    output logic             spareOeN,
    output logic             gate,
    output ssa_pot_t         potPins
);
    // match action of a compare channel on its pin
    function automatic logic ccAction(input ssa_ccmode_t m, input logic cur);
        case (m)
            CC_SET:    ccAction = 1'b1;
            CC_CLEAR:  ccAction = 1'b0;
            CC_TOGGLE: ccAction = ~cur;
            default:   ccAction = cur;
        endcase
    endfunction

    function automatic logic [6:0] tapOf(input logic [CW-1:0] per);
        tapOf = 7'(per >> `SSA_TAP_SHIFT);
    endfunction

    logic [CW-1:0]          timer_r;
    logic [1:0]             ctrl_r;
    logic [15:0]            charge_r;
    logic [7:0]             speed_r;
    logic [15:0]            pulse_r;
    logic [`SSA_ST_W-1:0]   stat_r;
    logic [`SSA_ST_W-1:0]   mask_r;
    logic [7:0]             result_r;
    logic [6:0]             tap_r;
    ssa_ccmode_t            c1Mode_r;
    logic [CW-1:0]          c1Val_r;
    logic                   spareInPrev_r;
    logic                   zcPrev_r;
    logic                   sensePrev_r;
    logic [CW-1:0]          zcCap_r;
    logic [CW-1:0]          zcOld_r;
    ssa_conv_t              cst_r;
    logic [1:0]             term_r;
    logic [15:0]            wait_r;
    logic [CW-1:0]          start_r;
    logic [CW-1:0]          cnt_r [3];
    ssa_fire_t              fst_r;
    logic [CW-1:0]          fireCmp_r;
    logic [7:0]             pcnt_r;
    logic [1:0]             pulses_r;
    logic                   zcEdge;
    logic                   senseFall;
    logic                   spareRise;
    logic                   convDone;
    logic                   fireDone;
    logic [`SSA_ST_W-1:0]   events;
    logic [CW-1:0]          span;
    logic [CW-1:0]          above;
    logic [23:0]            quot;

    assign zcEdge    = zcPrev_r ^ zcIn;
    assign senseFall = sensePrev_r & ~senseIn;
    assign spareRise = ~spareInPrev_r & spareIn;
    assign convDone  = (cst_r == S_CALC);
    // a re-arming zero cross aborts the burst, so no done event then
    assign fireDone  = (fst_r == F_HIGH) && (pcnt_r <= 8'h01) && (pulses_r == 2'h2) &&
                       !(zcEdge && ctrl_r[`SSA_CTRL_FIRE]);
    assign events    = {(c1Mode_r == CC_CAPTURE) ? spareRise : (timer_r == c1Val_r),
                        fireDone, zcEdge, convDone};
    // full-scale terminal 0, wiper 1, offset 2
    assign span  = cnt_r[0] - cnt_r[2];
    assign above = cnt_r[1] - cnt_r[2];
    assign quot  = (span == '0) ? 24'h0000_00 : {above, 8'h00} / 24'(span);

    // free-running up count, no clock gating or prescale
    always_ff @(posedge mclk) begin
        if (srst) timer_r <= '0;
        else      timer_r <= timer_r + 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            // follow the line level so a high line at release is no edge
            zcPrev_r      <= zcIn;
            sensePrev_r   <= 1'b0;
            spareInPrev_r <= 1'b0;
        end else begin
            zcPrev_r      <= zcIn;
            sensePrev_r   <= senseIn;
            spareInPrev_r <= spareIn;
        end
    end

    // line channel capture on both edges; two stamps span half a cycle, the tap a full one
    always_ff @(posedge mclk) begin
        if (srst) begin
            zcCap_r <= '0;
            zcOld_r <= '0;
            tap_r   <= '0;
        end else if (zcEdge) begin
            zcCap_r <= timer_r;
            zcOld_r <= zcCap_r;
            tap_r   <= tapOf(timer_r - zcOld_r);
        end
    end

    // conversion sequencer over the three pot terminals
    always_ff @(posedge mclk) begin
        if (srst) begin
            cst_r   <= S_IDLE;
            term_r  <= 2'h0;
            wait_r  <= 16'h0000;
            start_r <= '0;
            potPins <= '{drv: 3'h0, oeN: 3'h7};
            for (int i = 0; i < 3; i++) cnt_r[i] <= '0;
        end else begin
            case (cst_r)
                S_IDLE: begin
                    potPins.oeN <= 3'h7;
                    if (ctrl_r[`SSA_CTRL_CONV]) begin
                        cst_r  <= S_CHARGE;
                        term_r <= 2'h0;
                        wait_r <= charge_r;
                    end
                end
                S_CHARGE: begin
                    potPins.drv         <= 3'h7;
                    potPins.oeN         <= 3'h7;
                    potPins.oeN[term_r] <= 1'b0;
                    if (wait_r <= 16'h0001) cst_r <= S_WAITZC;
                    else                    wait_r <= wait_r - 1'b1;
                end
                S_WAITZC: begin
                    if (zcEdge) begin
                        cst_r               <= S_DISCH;
                        start_r             <= timer_r;
                        potPins.drv[term_r] <= 1'b0;
                    end
                end
                S_DISCH: begin
                    if (senseFall) begin
                        cnt_r[term_r] <= timer_r - start_r;
                        potPins.oeN   <= 3'h7;
                        if (term_r == 2'h2) begin
                            cst_r <= S_CALC;
                        end else begin
                            term_r <= term_r + 1'b1;
                            wait_r <= charge_r;
                            cst_r  <= S_CHARGE;
                        end
                    end
                end
                S_CALC:  cst_r <= S_IDLE;
                default: cst_r <= S_IDLE;
            endcase
        end
    end

    // saturating code
    always_ff @(posedge mclk) begin
        if (srst)                        result_r <= 8'h00;
        else if (convDone) begin
            if (cnt_r[1] <= cnt_r[2])     result_r <= 8'h00;
            else if (cnt_r[1] >= cnt_r[0]) result_r <= `SSA_CODE_MAX;
            else                         result_r <= quot[7:0];
        end
    end

    // gate firing: compare sets the pin, three pulses, low otherwise
    always_ff @(posedge mclk) begin
        if (srst) begin
            fst_r     <= F_IDLE;
            fireCmp_r <= '0;
            pcnt_r    <= 8'h00;
            pulses_r  <= 2'h0;
            gate      <= 1'b0;
        end else if (zcEdge && ctrl_r[`SSA_CTRL_FIRE]) begin
            fst_r     <= F_ARMED;
            fireCmp_r <= timer_r + CW'(speed_r) * CW'(tap_r);
            gate      <= 1'b0;
        end else begin
            case (fst_r)
                F_ARMED: begin
                    if (timer_r == fireCmp_r) begin
                        gate     <= ccAction(CC_SET, gate);
                        fst_r    <= F_HIGH;
                        pcnt_r   <= pulse_r[7:0];
                        pulses_r <= 2'h0;
                    end
                end
                F_HIGH: begin
                    if (pcnt_r <= 8'h01) begin
                        gate <= 1'b0;
                        if (pulses_r == 2'h2) begin
                            fst_r <= F_IDLE;
                        end else begin
                            fst_r    <= F_GAP;
                            pulses_r <= pulses_r + 1'b1;
                            pcnt_r   <= pulse_r[15:8];
                        end
                    end else begin
                        pcnt_r <= pcnt_r - 1'b1;
                    end
                end
                F_GAP: begin
                    if (pcnt_r <= 8'h01) begin
                        gate   <= 1'b1;
                        fst_r  <= F_HIGH;
                        pcnt_r <= pulse_r[7:0];
                    end else begin
                        pcnt_r <= pcnt_r - 1'b1;
                    end
                end
                default: begin
                    fst_r <= F_IDLE;
                    gate  <= 1'b0;
                end
            endcase
        end
    end

    // spare channel: capture from its pin or compare action on it
    always_ff @(posedge mclk) begin
        if (srst) begin
            spareOut <= 1'b0;
            spareOeN <= 1'b1;
        end else begin
            spareOeN <= (c1Mode_r == CC_CAPTURE);
            if (c1Mode_r != CC_CAPTURE && timer_r == c1Val_r)
                spareOut <= ccAction(c1Mode_r, spareOut);
        end
    end

    // register writes; a capture beats a same-cycle software write
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_r   <= 2'h0;
            charge_r <= `SSA_CHARGE_RST;
            speed_r  <= 8'h00;
            pulse_r  <= `SSA_PULSE_RST;
            mask_r   <= '0;
            c1Mode_r <= CC_CAPTURE;
            c1Val_r  <= '0;
        end else begin
            if (wrStb) begin
                case (addr)
                    `SSA_OFS_CTRL:   ctrl_r   <= wdata[1:0];
                    `SSA_OFS_CHARGE: charge_r <= wdata[15:0];
                    `SSA_OFS_SPEED:  speed_r  <= wdata[7:0];
                    `SSA_OFS_PULSE:  pulse_r  <= wdata[15:0];
                    `SSA_OFS_MASK:   mask_r   <= wdata[`SSA_ST_W-1:0];
                    `SSA_OFS_C1CTL:  c1Mode_r <= ssa_ccmode_t'(wdata[1:0]);
                    `SSA_OFS_C1VAL:  c1Val_r  <= wdata[CW-1:0];
                    default:         ;
                endcase
            end
            if (c1Mode_r == CC_CAPTURE && spareRise) c1Val_r <= timer_r;
        end
    end

    // sticky status, write one to clear, new event wins
    always_ff @(posedge mclk) begin
        if (srst) stat_r <= '0;
        else if (wrStb && addr == `SSA_OFS_STAT)
            stat_r <= (stat_r & ~wdata[`SSA_ST_W-1:0]) | events;
        else
            stat_r <= stat_r | events;
    end

    always_ff @(posedge mclk) begin
        if (srst) irq <= 1'b0;
        else      irq <= |((stat_r | events) & mask_r);
    end

    always_ff @(posedge mclk) begin
        if (srst) rdata <= 32'h0000_0000;
        else if (rdStb) begin
            case (addr)
                `SSA_OFS_CTRL:   rdata <= {30'h0, ctrl_r};
                `SSA_OFS_CHARGE: rdata <= {16'h0000, charge_r};
                `SSA_OFS_SPEED:  rdata <= {24'h00_0000, speed_r};
                `SSA_OFS_PULSE:  rdata <= {16'h0000, pulse_r};
                `SSA_OFS_STAT:   rdata <= 32'(stat_r);
                `SSA_OFS_MASK:   rdata <= 32'(mask_r);
                `SSA_OFS_RESULT: rdata <= {24'h00_0000, result_r};
                `SSA_OFS_TIMER:  rdata <= 32'(timer_r);
                `SSA_OFS_TAP:    rdata <= {25'h000_0000, tap_r};
                `SSA_OFS_C1CTL:  rdata <= {30'h0, c1Mode_r};
                `SSA_OFS_C1VAL:  rdata <= 32'(c1Val_r);
                default:         rdata <= 32'h0000_0000;
            endcase
        end else rdata <= 32'h0000_0000;
    end

    property p_timer_inc;
        @(posedge mclk) disable iff (srst)
        !$past(srst) |-> timer_r == $past(timer_r) + 1'b1;
    endproperty
    a_timer_inc: assert property (p_timer_inc) else $error("timer did not count up");

    property p_zc_cap;
        @(posedge mclk) disable iff (srst)
        zcEdge |=> zcCap_r == $past(timer_r) && zcOld_r == $past(zcCap_r);
    endproperty
    a_zc_cap: assert property (p_zc_cap) else $error("zero-cross capture wrong");

    property p_tap;
        @(posedge mclk) disable iff (srst)
        zcEdge |=> tap_r == tapOf(zcCap_r - $past(zcOld_r));
    endproperty
    a_tap: assert property (p_tap) else $error("tick size not cycle over 512");

    property p_disch_zc;
        @(posedge mclk) disable iff (srst)
        cst_r == S_WAITZC && !zcEdge |=> cst_r != S_DISCH;
    endproperty
    a_disch_zc: assert property (p_disch_zc) else $error("discharge without zero cross");

    property p_charge_pin;
        @(posedge mclk) disable iff (srst)
        cst_r == S_CHARGE && $past(cst_r) == S_CHARGE |->
            !potPins.oeN[term_r] && potPins.drv[term_r];
    endproperty
    a_charge_pin: assert property (p_charge_pin) else $error("terminal not charging");

    property p_capture;
        @(posedge mclk) disable iff (srst)
        cst_r == S_DISCH && senseFall |=> cnt_r[$past(term_r)] == $past(timer_r - start_r);
    endproperty
    a_capture: assert property (p_capture) else $error("discharge count wrong");

    property p_sat_low;
        @(posedge mclk) disable iff (srst)
        convDone && cnt_r[1] <= cnt_r[2] |=> result_r == 8'h00;
    endproperty
    a_sat_low: assert property (p_sat_low) else $error("code not saturated low");

    property p_gate_idle;
        @(posedge mclk) disable iff (srst)
        fst_r == F_IDLE || fst_r == F_ARMED || fst_r == F_GAP |-> !gate;
    endproperty
    a_gate_idle: assert property (p_gate_idle) else $error("gate high outside pulse");

    property p_three;
        @(posedge mclk) disable iff (srst)
        fst_r == F_GAP |-> pulses_r inside {2'h1, 2'h2};
    endproperty
    a_three: assert property (p_three) else $error("pulse count out of range");
endmodule

// ### verif/ssa_pot_model.sv
// rc network behind the three pot terminals and the sense pin
`timescale 1ns/100ps
module ssa_pot_model
    import ssa_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire ssa_pot_t    potPins,
    input  wire logic [47:0] disCyc,
    output logic             senseIn
);
    logic        charged_r;
    logic [15:0] elapsed_r;

    // driven high recharges, driven low drains, floating holds the charge
    always_ff @(posedge mclk) begin
        if (srst) begin
            charged_r <= 1'b0;
            elapsed_r <= 16'h0000;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (!potPins.oeN[i] && potPins.drv[i]) begin
                    charged_r <= 1'b1;
                    elapsed_r <= 16'h0000;
                end else if (!potPins.oeN[i] && charged_r) begin
                    elapsed_r <= elapsed_r + 16'h0001;
                    // each terminal has its own drain time to the threshold
                    if (elapsed_r + 16'h0001 >= disCyc[i*16 +: 16]) begin
                        charged_r <= 1'b0;
                    end
                end
            end
        end
    end
    assign senseIn = charged_r;
endmodule

// ### verif/test_ssa_top.sv
// self-checking bench for the set-point converter and gate pulser
`timescale 1ns/100ps
`include "ssa_cfg.svh"
module test_ssa_top
    import ssa_pkg::*;
;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    localparam logic [31:0] ONE  = 32'h0000_0001;
    logic        mclk    = 1'b0;
    logic        srst    = 1'b1;
    logic [7:0]  addr    = 8'h00;
    logic [31:0] wdata   = 32'h0000_0000;
    logic        wrStb   = 1'b0;
    logic        rdStb   = 1'b0;
    logic        zcIn    = 1'b0;
    logic        spareIn = 1'b0;
    logic [47:0] disCyc  = 48'h0000_0000_0000;
    logic [31:0] rdata;
    logic        irq;
    logic        senseIn;
    logic        spareOut;
    logic        spareOeN;
    logic        gate;
    ssa_pot_t    potPins;
    int          miscompares = 0;
    int          check_count = 0;
    int          zcPer       = 400;
    int          zcCnt       = 0;

    always #50 mclk = ~mclk;

    // line zero-cross source, toggling every zcPer cycles
    always @(posedge mclk) begin
        if (zcCnt >= zcPer - 1) begin
            zcCnt <= 0;
            zcIn  <= ~zcIn;
        end else begin
            zcCnt <= zcCnt + 1;
        end
    end

    ssa_top ssa_top_inst (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata),
        .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata), .irq(irq), .senseIn(senseIn),
        .zcIn(zcIn), .spareIn(spareIn), .spareOut(spareOut), .spareOeN(spareOeN),
        .gate(gate), .potPins(potPins));
    ssa_pot_model ssa_pot_model_inst (.mclk(mclk), .srst(srst), .potPins(potPins),
        .disCyc(disCyc), .senseIn(senseIn));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wrStb <= 1'b1;
        @(posedge mclk);
        wrStb <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        rdStb <= 1'b1;
        @(posedge mclk);
        rdStb <= 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask

    function automatic logic [31:0] code(input int f, input int w, input int o);
        if (w <= o) return ZERO;
        if (w >= f) return 32'h0000_00FF;
        return 32'((w - o) * 256 / (f - o));
    endfunction

    task automatic test_reset;
        logic [31:0] a;
        logic [31:0] b;
        chk(32'(gate), ZERO);
        chk(32'(potPins), 32'h0000_0007);
        chk(32'(irq), ZERO);
        chk(32'(spareOeN), ONE);
        rd(`SSA_OFS_CHARGE, a);
        chk(a, 32'h0000_0400);
        rd(`SSA_OFS_PULSE, a);
        chk(a, 32'h0000_0A14);
        rd(`SSA_OFS_RESULT, a);
        wr(`SSA_OFS_RESULT, 32'h0000_00AA);
        rd(`SSA_OFS_RESULT, b);
        chk(b, a);
        wr(8'h30, 32'hFFFF_FFFF);
        rd(8'h30, a);
        chk(a, ZERO);
        rd(`SSA_OFS_TIMER, a);
        rd(`SSA_OFS_TIMER, b);
        chk(b - a, 32'h0000_0002);
    endtask

    task automatic run_conv(input int f, input int w, input int o);
        logic [31:0] d;
        int          n;
        disCyc <= {16'(o), 16'(w), 16'(f)};
        wr(`SSA_OFS_STAT, ONE);
        wr(`SSA_OFS_CTRL, ONE);
        n = 0;
        while (potPins.oeN == 3'b111 && n < 10) begin
            @(negedge mclk);
            n++;
        end
        chk(32'(potPins), 32'h0000_003E);
        n = 0;
        while (potPins.drv[0] && n < 1000) begin
            @(negedge mclk);
            n++;
        end
        chk(32'(n >= 8), ONE);
        chk(32'(zcCnt <= 3), ONE);
        n = 0;
        while (!irq && n < 4000) begin
            @(negedge mclk);
            n++;
        end
        chk(32'(irq), ONE);
        wr(`SSA_OFS_CTRL, ZERO);
        rd(`SSA_OFS_RESULT, d);
        chk(d, code(f, w, o));
        wr(`SSA_OFS_STAT, ONE);
        tick(2);
        @(negedge mclk);
        // zero-cross bit keeps setting but is masked out
        chk(32'(irq), ZERO);
        tick(2500);
    endtask

    task automatic test_conv;
        wr(`SSA_OFS_CHARGE, 32'h0000_0008);
        wr(`SSA_OFS_MASK, ONE);
        run_conv(300, 150, 50);
        run_conv(300, 40, 50);
        run_conv(300, 320, 50);
        run_conv(306, 178, 50);
    endtask

    task automatic test_spare;
        logic [31:0] t;
        logic [31:0] d;
        for (int m = 1; m < 4; m++) begin
            wr(`SSA_OFS_C1CTL, 32'(m));
            rd(`SSA_OFS_TIMER, t);
            wr(`SSA_OFS_C1VAL, (t + 32'h0000_0020) & 32'h0000_FFFF);
            tick(40);
            @(negedge mclk);
            // set, then clear, then toggle from low
            chk(32'(spareOut), 32'(m != 2));
            chk(32'(spareOeN), ZERO);
        end
        rd(`SSA_OFS_STAT, d);
        chk(32'(d[3]), ONE);
        wr(`SSA_OFS_C1CTL, ZERO);
        rd(`SSA_OFS_TIMER, t);
        @(posedge mclk);
        spareIn <= 1'b1;
        rd(`SSA_OFS_C1VAL, d);
        chk(32'(d - t >= 2 && d - t <= 4), ONE);
        chk(32'(spareOeN), ONE);
        @(posedge mclk);
        spareIn <= 1'b0;
    endtask

    task automatic test_fire;
        logic [31:0] d;
        logic        z;
        int          n;
        zcPer = 1024;
        wr(`SSA_OFS_SPEED, 32'h0000_0014);
        wr(`SSA_OFS_PULSE, 32'h0000_0503);
        wr(`SSA_OFS_MASK, 32'h0000_0004);
        wr(`SSA_OFS_CTRL, 32'h0000_0002);
        tick(3200);
        rd(`SSA_OFS_TAP, d);
        chk(d, 32'h0000_0004);
        rd(`SSA_OFS_STAT, d);
        chk(32'(d[1]), ONE);
        wr(`SSA_OFS_STAT, 32'h0000_0004);
        z = zcIn;
        n = 0;
        while (zcIn == z && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        n = 0;
        while (!gate && n < 500) begin
            @(negedge mclk);
            n++;
        end
        // compare offset is speed times tap, plus input and output stages
        chk(32'(n >= 80 && n <= 86), ONE);
        for (int p = 0; p < 3; p++) begin
            n = 0;
            while (gate && n < 300) begin
                @(negedge mclk);
                n++;
            end
            chk(32'(n), 32'h0000_0003);
            n = 0;
            while (!gate && n < 300 && p < 2) begin
                @(negedge mclk);
                n++;
            end
            if (p < 2) chk(32'(n), 32'h0000_0005);
        end
        tick(3);
        @(negedge mclk);
        chk(32'(irq), ONE);
        chk(32'(gate), ZERO);
    endtask

    // reset in the middle of a charge phase
    task automatic test_midreset;
        logic [31:0] d;
        wr(`SSA_OFS_CTRL, ONE);
        tick(4);
        @(negedge mclk);
        chk(32'(potPins.oeN), 32'h0000_0006);
        @(posedge mclk);
        srst <= 1'b1;
        tick(2);
        srst <= 1'b0;
        chk(32'(potPins), 32'h0000_0007);
        chk(32'(gate), ZERO);
        rd(`SSA_OFS_CTRL, d);
        chk(d, ZERO);
        rd(`SSA_OFS_TIMER, d);
        chk(d, 32'h0000_0003);
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #6_000_000;
        miscompares++;
        finish_test;
    end

    initial begin
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        test_reset;
        test_conv;
        test_spare;
        test_fire;
        test_midreset;
        finish_test;
    end
endmodule
